/* pkg/antenna_pkg.sv */
package antenna_pkg;

  // Register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CARRIER_CTRL_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] MOD_DEPTH_ADDR = 8'h15;
  localparam logic [ADDR_W-1:0] SOURCE_SEL_ADDR = 8'h16;

  // Reset values, reserved bits included
  localparam logic [DATA_W-1:0] CARRIER_CTRL_RESET = 8'h80;
  localparam logic [DATA_W-1:0] MOD_DEPTH_RESET = 8'h40;
  localparam logic [DATA_W-1:0] SOURCE_SEL_RESET = 8'h10;

  // Writable bits; all others keep their reset value
  localparam logic [DATA_W-1:0] CARRIER_CTRL_WMASK = 8'h4B;
  localparam logic [DATA_W-1:0] MOD_DEPTH_WMASK = 8'h40;
  localparam logic [DATA_W-1:0] SOURCE_SEL_WMASK = 8'h30;

  // Field positions
  localparam int INVERT_BIT = 6;
  localparam int CW_BIT = 3;
  localparam int PIN_SEL_LSB = 0;
  localparam int FORCE_BIT = 6;
  localparam int SOURCE_LSB = 4;

  // Carrier synthesis from the system clock
  localparam longint CARRIER_HZ = 13_560_000;
  localparam longint CLK_HZ = 200_000_000;
  localparam int NCO_W = 32;
  localparam logic [NCO_W-1:0] NCO_INC = NCO_W'((CARRIER_HZ << NCO_W) / CLK_HZ);

  // Drive strength applied to the pins
  localparam int COND_W = 6;
  localparam logic [COND_W-1:0] COND_FULL = 6'h3F;
  localparam logic [COND_W-1:0] COND_ZERO = 6'h00;

  typedef enum logic [1:0] {
    SRC_TRISTATE = 2'b00,
    SRC_ENVELOPE = 2'b01,
    SRC_RESERVED = 2'b10,
    SRC_HIGH = 2'b11
  } source_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic carrier_invert;
    logic unmodulated_carrier_en;
    logic [1:0] modulated_carrier_pin_sel;
    logic full_depth_ask_force;
    source_type driver_source_sel;
  } ctrl_type;

  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_type;

endpackage : antenna_pkg

/* hdl/carrier_nco.sv */
`timescale 1ns/1ps
module carrier_nco #(
  parameter int WIDTH = antenna_pkg::NCO_W,
  parameter logic [WIDTH-1:0] INC = antenna_pkg::NCO_INC
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic carrier
);
  import antenna_pkg::*;

  logic [WIDTH-1:0] phase_reg;
  logic [WIDTH-1:0] phase_next;

  // Phase accumulator; INC is truncated so the average rate is slightly low, edges jitter by one clock
  always_comb begin
    phase_next = phase_reg + INC;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Top bit is a flip-flop, so the carrier is glitch free
  assign carrier = phase_reg[WIDTH-1];

endmodule : carrier_nco

/* hdl/antenna_regs.sv */
`timescale 1ns/1ps
module antenna_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input antenna_pkg::bus_req_type bus_req,
  output logic [antenna_pkg::DATA_W-1:0] rd_data,
  output antenna_pkg::ctrl_type ctrl
);
  import antenna_pkg::*;

  logic [DATA_W-1:0] carrier_ctrl_reg, carrier_ctrl_next;
  logic [DATA_W-1:0] mod_depth_reg, mod_depth_next;
  logic [DATA_W-1:0] source_sel_reg, source_sel_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;

  // Merge only writable bits; reserved bits never move
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_val,
      input logic [DATA_W-1:0] new_val, input logic [DATA_W-1:0] mask);
    merge = (old_val & ~mask) | (new_val & mask);
  endfunction : merge

  // Write decode and read mux; unmapped reads return zero
  always_comb begin
    carrier_ctrl_next = carrier_ctrl_reg;
    mod_depth_next = mod_depth_reg;
    source_sel_next = source_sel_reg;
    rd_data_next = '0;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        CARRIER_CTRL_ADDR: carrier_ctrl_next = merge(carrier_ctrl_reg, bus_req.wdata,
            CARRIER_CTRL_WMASK);
        MOD_DEPTH_ADDR: mod_depth_next = merge(mod_depth_reg, bus_req.wdata,
            MOD_DEPTH_WMASK);
        SOURCE_SEL_ADDR: source_sel_next = merge(source_sel_reg, bus_req.wdata,
            SOURCE_SEL_WMASK);
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CARRIER_CTRL_ADDR: rd_data_next = carrier_ctrl_reg;
        MOD_DEPTH_ADDR: rd_data_next = mod_depth_reg;
        SOURCE_SEL_ADDR: rd_data_next = source_sel_reg;
        default: rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      carrier_ctrl_reg <= CARRIER_CTRL_RESET;
      mod_depth_reg <= MOD_DEPTH_RESET;
      source_sel_reg <= SOURCE_SEL_RESET;
      rd_data_reg <= '0;
    end else begin
      carrier_ctrl_reg <= carrier_ctrl_next;
      mod_depth_reg <= mod_depth_next;
      source_sel_reg <= source_sel_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // Field extraction
  assign ctrl.carrier_invert = carrier_ctrl_reg[INVERT_BIT];
  assign ctrl.unmodulated_carrier_en = carrier_ctrl_reg[CW_BIT];
  assign ctrl.modulated_carrier_pin_sel = carrier_ctrl_reg[PIN_SEL_LSB +: 2];
  assign ctrl.full_depth_ask_force = mod_depth_reg[FORCE_BIT];
  assign ctrl.driver_source_sel = source_type'(source_sel_reg[SOURCE_LSB +: 2]);
  assign rd_data = rd_data_reg;

endmodule : antenna_regs

/* hdl/antenna_driver_control.sv */
`timescale 1ns/1ps
// Summary of operation
// - Invert carrier on both pins when enabled
// - Unmodulated carrier bit drives continuous carrier
// - Pin select field routes modulated carrier
// - Force bit gives full depth ASK
// - Source 00 floats only in power-down
// - Source 01 feeds Miller envelope to drivers
// - Source 11 drives static high, invertible
// - Control registers set the pin states
module antenna_driver_control (
  input wire logic clk_sys,
  input wire logic rst,
  input antenna_pkg::bus_req_type bus_req,
  output logic [antenna_pkg::DATA_W-1:0] rd_data,
  input wire logic modulation_envelope,
  input wire logic power_down,
  input wire logic [antenna_pkg::COND_W-1:0] modulation_conductance_setting,
  output antenna_pkg::pin_type antenna_out_a,
  output antenna_pkg::pin_type antenna_out_b,
  output logic [antenna_pkg::COND_W-1:0] drive_conductance
);
  import antenna_pkg::*;

  ctrl_type ctrl;
  logic carrier;
  pin_type pin_a_reg, pin_a_next;
  pin_type pin_b_reg, pin_b_next;
  logic [COND_W-1:0] cond_reg, cond_next;
  logic any_modulated;
  logic in_pause;

  // Register file on the plain port
  antenna_regs u_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .ctrl(ctrl)
  );

  // Carrier tone from the system clock
  carrier_nco #(
    .WIDTH(NCO_W),
    .INC(NCO_INC)
  ) u_nco (
    .clk_sys(clk_sys),
    .rst(rst),
    .carrier(carrier)
  );

  // Common pin decode, used for both drivers
  function automatic pin_type pin_drive(
    input ctrl_type c,
    input logic pin_en,
    input logic carr,
    input logic env,
    input logic pd
  );
    pin_type p;
    logic tri_src;
    p.level = 1'b0;
    p.oe_n = 1'b0;
    tri_src = (c.driver_source_sel == SRC_TRISTATE) ||
              (c.driver_source_sel == SRC_RESERVED);
    if (tri_src && pd) begin
      // Only power-down may release the pin
      p.oe_n = 1'b1;
    end else if (c.unmodulated_carrier_en) begin
      // Continuous carrier, no envelope applied
      p.level = carr ^ c.carrier_invert;
    end else if (pin_en) begin
      unique case (c.driver_source_sel)
        SRC_ENVELOPE: begin
          // Pause keeps the tone unless full depth is forced
          p.level = (carr & (env | ~c.full_depth_ask_force)) ^ c.carrier_invert;
        end
        SRC_HIGH: begin
          p.level = 1'b1 ^ c.carrier_invert;
        end
        SRC_TRISTATE: begin
          p.level = 1'b0;
        end
        SRC_RESERVED: begin
          p.level = 1'b0;
        end
      endcase
    end else begin
      // Disabled driver idles low, never floats
      p.level = 1'b0;
    end
    return p;
  endfunction : pin_drive

  // Pause and drive-strength decode
  always_comb begin
    any_modulated = (ctrl.modulated_carrier_pin_sel != 2'b00) &&
                    !ctrl.unmodulated_carrier_en;
    in_pause = any_modulated && (ctrl.driver_source_sel == SRC_ENVELOPE) &&
               !modulation_envelope;
  end

  // Next pin states; bit 0 of the select is pin a, bit 1 pin b
  always_comb begin
    pin_a_next = pin_drive(ctrl, ctrl.modulated_carrier_pin_sel[0], carrier,
                           modulation_envelope, power_down);
    pin_b_next = pin_drive(ctrl, ctrl.modulated_carrier_pin_sel[1], carrier,
                           modulation_envelope, power_down);
    if (in_pause) begin
      // Analog depth ignored when full depth is forced
      cond_next = ctrl.full_depth_ask_force ? COND_ZERO
                                            : modulation_conductance_setting;
    end else begin
      cond_next = COND_FULL;
    end
  end

  // Pins come from flip-flops so the drivers see no decode glitches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_a_reg <= '0;
      pin_b_reg <= '0;
      cond_reg <= COND_FULL;
    end else begin
      pin_a_reg <= pin_a_next;
      pin_b_reg <= pin_b_next;
      cond_reg <= cond_next;
    end
  end

  assign antenna_out_a = pin_a_reg;
  assign antenna_out_b = pin_b_reg;
  assign drive_conductance = cond_reg;

  // Checks
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic tri_sel;
  assign tri_sel = (ctrl.driver_source_sel == SRC_TRISTATE) ||
                   (ctrl.driver_source_sel == SRC_RESERVED);

  a_invert_high:
    assert property (
      (ctrl.driver_source_sel == SRC_HIGH) && ctrl.modulated_carrier_pin_sel[0] &&
      !ctrl.unmodulated_carrier_en
      |=> antenna_out_a.level == !$past(ctrl.carrier_invert) && !antenna_out_a.oe_n
    ) else $error("static high level wrong on pin a");

  a_cw_both_pins:
    assert property (
      ctrl.unmodulated_carrier_en && !(tri_sel && power_down)
      |=> antenna_out_a.level == ($past(carrier) ^ $past(ctrl.carrier_invert)) &&
          antenna_out_b.level == antenna_out_a.level
    ) else $error("unmodulated carrier not on both pins");

  a_invert_flip:
    assert property (
      ctrl.unmodulated_carrier_en && ctrl.carrier_invert && !(tri_sel && power_down)
      |=> antenna_out_a.level != $past(carrier)
    ) else $error("carrier not inverted");

  a_pins_off:
    assert property (
      (ctrl.modulated_carrier_pin_sel == 2'b00) && !ctrl.unmodulated_carrier_en &&
      !(tri_sel && power_down)
      |=> !antenna_out_a.level && !antenna_out_b.level
    ) else $error("pins driven with carrier disabled");

  a_pin_b_only:
    assert property (
      (ctrl.modulated_carrier_pin_sel == 2'b10) && !ctrl.unmodulated_carrier_en &&
      (ctrl.driver_source_sel == SRC_HIGH)
      |=> !antenna_out_a.level && antenna_out_b.level == !$past(ctrl.carrier_invert)
    ) else $error("pin select b routing wrong");

  a_float_pd:
    assert property (
      tri_sel && power_down |=> antenna_out_a.oe_n && antenna_out_b.oe_n
    ) else $error("drivers not floating in power-down");

  a_no_float:
    assert property (
      !power_down |=> !antenna_out_a.oe_n && !antenna_out_b.oe_n
    ) else $error("driver floated outside power-down");

  a_full_depth:
    assert property (
      ctrl.full_depth_ask_force && in_pause && ctrl.modulated_carrier_pin_sel[0]
      |=> !antenna_out_a.level == !$past(ctrl.carrier_invert) &&
          drive_conductance == COND_ZERO
    ) else $error("pause not at full depth");

  a_partial_depth:
    assert property (
      !ctrl.full_depth_ask_force && in_pause
      |=> drive_conductance == $past(modulation_conductance_setting)
    ) else $error("conductance setting not applied");

  a_envelope_on:
    assert property (
      (ctrl.driver_source_sel == SRC_ENVELOPE) && ctrl.modulated_carrier_pin_sel[0] &&
      !ctrl.unmodulated_carrier_en && modulation_envelope
      |=> antenna_out_a.level == ($past(carrier) ^ $past(ctrl.carrier_invert))
    ) else $error("envelope high but carrier missing");

  a_write_to_pin:
    assert property (
      bus_req.wr && (bus_req.addr == SOURCE_SEL_ADDR) && (bus_req.wdata[5:4] == 2'b11) &&
      ctrl.modulated_carrier_pin_sel[0] && !ctrl.unmodulated_carrier_en && !bus_req.rd
      ##1 !bus_req.wr && ctrl.modulated_carrier_pin_sel[0] && !ctrl.unmodulated_carrier_en
      |=> antenna_out_a.level == !$past(ctrl.carrier_invert)
    ) else $error("source write not reflected on pin");

  a_reserved_read:
    assert property (
      bus_req.rd && (bus_req.addr == CARRIER_CTRL_ADDR)
      |=> rd_data[7] && (rd_data[5:4] == 2'b00) && !rd_data[2]
    ) else $error("reserved bits of carrier control changed");

  a_reserved_src:
    assert property (
      bus_req.rd && (bus_req.addr == SOURCE_SEL_ADDR)
      |=> (rd_data[7:6] == 2'b00) && (rd_data[3:0] == 4'h0)
    ) else $error("reserved bits of source select changed");

  // Inversion must reach pin b as well, not only pin a
  a_invert_flip_b:
    assert property (
      ctrl.unmodulated_carrier_en && ctrl.carrier_invert && !(tri_sel && power_down)
      |=> antenna_out_b.level != $past(carrier)
    ) else $error("carrier not inverted on pin b");

  a_pin_a_only:
    assert property (
      (ctrl.modulated_carrier_pin_sel == 2'b01) && !ctrl.unmodulated_carrier_en &&
      (ctrl.driver_source_sel == SRC_HIGH)
      |=> !antenna_out_b.level && antenna_out_a.level == !$past(ctrl.carrier_invert)
    ) else $error("pin select a routing wrong");

  // Stale read data would look like a second answer
  a_read_idle:
    assert property (
      !bus_req.rd |=> rd_data == '0
    ) else $error("read data outside a read cycle");

endmodule : antenna_driver_control

/* verification/antenna_network_model.sv */
`timescale 1ns/1ps
// Antenna network seen as two coil nodes; counts driven edges on each pin
module antenna_network_model (
  input wire logic clk_sys,
  input wire logic rst,
  input antenna_pkg::pin_type antenna_out_a,
  input antenna_pkg::pin_type antenna_out_b,
  input wire logic clear,
  output logic node_a,
  output logic node_b,
  output int toggles_a,
  output int toggles_b
);
  import antenna_pkg::*;

  // A released pin shows the inverse of its last value, so a float never passes as a level
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      node_a <= 1'b0;
      node_b <= 1'b0;
      toggles_a <= 0;
      toggles_b <= 0;
    end else begin
      node_a <= antenna_out_a.oe_n ? ~node_a : antenna_out_a.level;
      node_b <= antenna_out_b.oe_n ? ~node_b : antenna_out_b.level;
      if (clear) begin
        toggles_a <= 0;
        toggles_b <= 0;
      end else begin
        if (!antenna_out_a.oe_n && antenna_out_a.level !== node_a) toggles_a <= toggles_a + 1;
        if (!antenna_out_b.oe_n && antenna_out_b.level !== node_b) toggles_b <= toggles_b + 1;
      end
    end
  end
endmodule : antenna_network_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import antenna_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  bus_req_type bus_req = '0;
  logic env = 1'b1;
  logic power_down = 1'b0;
  logic [COND_W-1:0] cond_set = 6'h15;
  logic [DATA_W-1:0] rd_data;
  pin_type pin_a;
  pin_type pin_b;
  logic [COND_W-1:0] drive_conductance;
  logic clear = 1'b1;
  int toggles_a;
  int toggles_b;
  int err_count = 0;
  int n_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  antenna_driver_control antenna_driver_control_inst (.clk_sys(clk_sys), .rst(rst),
    .bus_req(bus_req), .rd_data(rd_data), .modulation_envelope(env),
    .power_down(power_down), .modulation_conductance_setting(cond_set),
    .antenna_out_a(pin_a), .antenna_out_b(pin_b), .drive_conductance(drive_conductance));

  antenna_network_model antenna_network_model_inst (.clk_sys(clk_sys), .rst(rst),
    .antenna_out_a(pin_a), .antenna_out_b(pin_b), .clear(clear), .node_a(),
    .node_b(), .toggles_a(toggles_a), .toggles_b(toggles_b));

  task report_and_stop;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One idle cycle between accesses keeps each strobe a clean single pulse
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    chk(rd_data, exp, "read data");
  endtask : rd

  task settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  // Expected pins as {level, oe_n}; level ignored while released
  task pins(input logic [1:0] ea, input logic [1:0] eb);
    chk({7'h00, pin_a.oe_n}, {7'h00, ea[0]}, "pin a enable");
    chk({7'h00, pin_b.oe_n}, {7'h00, eb[0]}, "pin b enable");
    if (!ea[0]) chk({7'h00, pin_a.level}, {7'h00, ea[1]}, "pin a level");
    if (!eb[0]) chk({7'h00, pin_b.level}, {7'h00, eb[1]}, "pin b level");
  endtask : pins

  task count_edges;
    @(posedge clk_sys);
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
    repeat (64) @(posedge clk_sys);
    #1;
  endtask : count_edges

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    settle;
    pins(2'b00, 2'b00);
    rd(CARRIER_CTRL_ADDR, 8'h80);
    rd(MOD_DEPTH_ADDR, 8'h40);
    rd(SOURCE_SEL_ADDR, 8'h10);
    rd(8'h17, 8'h00);
    for (int a = 20; a < 24; a++) wr(8'(a), 8'hFF);
    rd(CARRIER_CTRL_ADDR, 8'hCB);
    rd(MOD_DEPTH_ADDR, 8'h40);
    rd(SOURCE_SEL_ADDR, 8'h30);
    rd(8'h17, 8'h00);
    // Every source code under power-down: only 00 and 10 release the pins
    wr(CARRIER_CTRL_ADDR, 8'h03);
    @(posedge clk_sys);
    power_down <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(SOURCE_SEL_ADDR, 8'(s << 4));
      settle;
      chk({7'h00, pin_a.oe_n}, {7'h00, ~s[0]}, "float a");
      chk({7'h00, pin_b.oe_n}, {7'h00, ~s[0]}, "float b");
    end
    @(posedge clk_sys);
    power_down <= 1'b0;
    wr(SOURCE_SEL_ADDR, 8'h00);
    settle;
    pins(2'b00, 2'b00);
    // Static high through each pin selection
    wr(SOURCE_SEL_ADDR, 8'h30);
    for (int p = 0; p < 4; p++) begin
      wr(CARRIER_CTRL_ADDR, 8'(p));
      settle;
      pins({p[0], 1'b0}, {p[1], 1'b0});
    end
    wr(CARRIER_CTRL_ADDR, 8'h43);
    settle;
    pins(2'b00, 2'b00);
    // Envelope pause, forced and not forced, with inversion on
    wr(SOURCE_SEL_ADDR, 8'h10);
    @(posedge clk_sys);
    env <= 1'b0;
    settle;
    pins(2'b10, 2'b10);
    chk({2'b00, drive_conductance}, 8'h00, "forced depth");
    wr(MOD_DEPTH_ADDR, 8'h00);
    settle;
    chk({2'b00, drive_conductance}, {2'b00, cond_set}, "partial depth");
    @(posedge clk_sys);
    cond_set <= 6'h2A;
    settle;
    chk({2'b00, drive_conductance}, 8'h2A, "new depth setting");
    @(posedge clk_sys);
    env <= 1'b1;
    settle;
    chk({2'b00, drive_conductance}, 8'h3F, "no pause");
    count_edges;
    chk(8'(toggles_a >= 4), 8'h01, "carrier on a");
    wr(MOD_DEPTH_ADDR, 8'h40);
    @(posedge clk_sys);
    env <= 1'b0;
    count_edges;
    chk(8'(toggles_a), 8'h00, "paused carrier");
    // Unmodulated carrier overrides an idle selection and a pause
    wr(CARRIER_CTRL_ADDR, 8'h08);
    count_edges;
    chk(8'(toggles_a >= 4), 8'h01, "steady carrier a");
    chk(8'(toggles_b >= 4), 8'h01, "steady carrier b");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      #1;
      chk({7'h00, pin_a.level}, {7'h00, pin_b.level}, "pins in step");
    end
    wr(CARRIER_CTRL_ADDR, 8'h00);
    count_edges;
    chk(8'(toggles_a), 8'h00, "carrier off");
    // Reset in mid-run brings every register back to its default
    wr(CARRIER_CTRL_ADDR, 8'h4B);
    wr(MOD_DEPTH_ADDR, 8'h00);
    wr(SOURCE_SEL_ADDR, 8'h30);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(CARRIER_CTRL_ADDR, 8'h80);
    rd(MOD_DEPTH_ADDR, 8'h40);
    rd(SOURCE_SEL_ADDR, 8'h10);
    settle;
    pins(2'b00, 2'b00);
    report_and_stop;
  end

  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #100us;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule : tb_top
